// ---- hw/ces_edge_shaper.sv ----
// Carrier edge shaper: configuration registers and edge sequencer
//
// How it works
// - The falling edge style is taken from bits 7:4 of the kind register, codes 1 to 6 valid.
// - The rising edge style is taken from bits 3:0 of the kind register with the same codes.
// - Codes 1, 2 and 3 shape the edge with one, two or three linear ramps, no table.
// - Code 4 shapes the edge from a table with no supply adaptation.
// - Code 5 shapes from a table, adapted to the supply, with the correction step.
// - Code 6 shapes from a table, adapted to the supply, without the correction step.
// - For linear falling edges bits 6:4 of the param register set the time constant.
// - For table falling edges bits 6:4 of the param register pick table 0 to 3.
// - For linear rising edges bits 2:0 of the param register set the time constant.
// - For table rising edges bits 2:0 of the param register pick table 0 to 3.
// - With bit 7 of the count register clear every transition state lasts one carrier cycle.
// - With bit 7 of the count register set every transition state lasts two carrier cycles.
// - Bits 4:0 of the count register give the number of states for both edges.
// - The level register maps linearly from no carrier at 0x00 to full carrier at 0xFF.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module ces_edge_shaper #(
  parameter int CARRIER_DIV = ces_pkg::CARRIER_CYCLES
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [15:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic MOD_I,
  input wire logic [7:0] AMP_SUPPLY_I,
  output logic [7:0] AMPL_O,
  output logic EDGE_BUSY_O
);

  initial
  begin
    if (CARRIER_DIV < 1 || CARRIER_DIV > 255)
      $error("ces_edge_shaper: CARRIER_DIV out of range");
  end

  typedef enum logic [1:0] {
    ST_HIGH = 2'b00,
    ST_FALL = 2'b01,
    ST_LOW = 2'b10,
    ST_RISE = 2'b11
  } ces_state_type;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic is_valid_style(input logic [3:0] sty, input logic [2:0] prm);
    is_valid_style = (sty >= 4'h1 && sty <= 4'h3)
      || (sty >= 4'h4 && sty <= 4'h6 && prm <= ces_pkg::LUT_INDEX_MAX);
  endfunction : is_valid_style

  function automatic logic [7:0] mix(input logic [7:0] a, input logic [7:0] b,
                                     input logic [7:0] f);
    logic [16:0] prod;
    logic [8:0] diff;
    diff = (b >= a) ? 9'(b - a) : 9'(a - b);
    prod = 17'(diff) * 17'(f) + 17'h0_0080;
    mix = (b >= a) ? 8'(a + 8'(prod[16:8])) : 8'(a - 8'(prod[16:8]));
  endfunction : mix

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] kind_ff, param_ff, count_ff, level_ff;
  logic [7:0] nxt_kind, nxt_param, nxt_count, nxt_level, nxt_rdata;
  logic [7:0] rdata_ff;
  ces_state_type state_ff, nxt_state;

  always_comb
  begin
    nxt_kind = kind_ff;
    nxt_param = param_ff;
    nxt_count = count_ff;
    nxt_level = level_ff;
    nxt_rdata = ces_pkg::READ_UNMAPPED;
    if (WR_I)
    begin
      unique case (ADDR_I)
        ces_pkg::ADDR_SHAPE_KIND: nxt_kind = WDATA_I;
        ces_pkg::ADDR_SHAPE_PARAM: nxt_param = WDATA_I;
        ces_pkg::ADDR_STEP_COUNT: nxt_count = WDATA_I;
        ces_pkg::ADDR_CARRIER_LEVEL: nxt_level = WDATA_I;
        default: nxt_kind = kind_ff;
      endcase
    end
    if (RD_I)
    begin
      unique case (ADDR_I)
        ces_pkg::ADDR_SHAPE_KIND: nxt_rdata = kind_ff;
        ces_pkg::ADDR_SHAPE_PARAM: nxt_rdata = param_ff;
        ces_pkg::ADDR_STEP_COUNT: nxt_rdata = count_ff;
        ces_pkg::ADDR_CARRIER_LEVEL: nxt_rdata = level_ff;
        ces_pkg::ADDR_EDGE_STATUS: nxt_rdata = {5'h00, EDGE_BUSY_O, state_ff};
        default: nxt_rdata = ces_pkg::READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      kind_ff <= ces_pkg::RST_SHAPE_KIND;
      param_ff <= ces_pkg::RST_SHAPE_PARAM;
      count_ff <= ces_pkg::RST_STEP_COUNT;
      level_ff <= ces_pkg::RST_CARRIER_LEVEL;
      rdata_ff <= ces_pkg::READ_UNMAPPED;
    end
    else
    begin
      kind_ff <= nxt_kind;
      param_ff <= nxt_param;
      count_ff <= nxt_count;
      level_ff <= nxt_level;
      rdata_ff <= nxt_rdata;
    end
  end

  assign RDATA_O = rdata_ff;

  // ----------------------------------------
  // Carrier cycle enable
  // ----------------------------------------
  logic tick;

  ces_tick_div #(.DIV(CARRIER_DIV)) u_div (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .tick_o(tick)
  );

  // ----------------------------------------
  // Edge sequencer
  // ----------------------------------------
  // Latched copies keep an edge immune to register writes while it runs
  logic [3:0] sty_ff, nxt_sty;
  logic [2:0] prm_ff, nxt_prm;
  logic dbl_ff, nxt_dbl;
  logic [4:0] num_ff, nxt_num;
  logic [7:0] lvl_ff, nxt_lvl;
  logic [4:0] idx_ff, nxt_idx;
  logic sub_ff, nxt_sub;
  logic [7:0] amp_ff, nxt_amp;
  logic [4:0] step;
  logic [7:0] prog, frac, lin_frac, lut_frac, knee, knee_lo;
  logic [12:0] prog_num;
  logic [3:0] fall_sty, rise_sty;
  logic [2:0] fall_prm, rise_prm;
  logic [4:0] cfg_num;
  logic edge_run;

  always_comb
  begin
    fall_sty = kind_ff[ces_pkg::FALL_KIND_LSB +: 4];
    rise_sty = kind_ff[ces_pkg::RISE_KIND_LSB +: 4];
    // Bits 7 and 3 of param and 6:5 of count are never looked at
    fall_prm = param_ff[ces_pkg::FALL_PARAM_LSB +: 3];
    rise_prm = param_ff[ces_pkg::RISE_PARAM_LSB +: 3];
    cfg_num = count_ff[ces_pkg::COUNT_LSB +: 5];
  end

  // Progress through the edge, 255/num_ff at the first state, 255 at the last state
  always_comb
  begin
    step = idx_ff + 5'h01;
    prog_num = 13'(step) * 13'h00FF;
    prog = (num_ff == 5'h00) ? 8'hFF : 8'(prog_num / 13'(num_ff));
    // Time constant moves the knee between the ramps
    knee = 8'(8'h40 + {prm_ff, 4'h0});
    knee_lo = {1'b0, knee[7:1]};
    unique case (sty_ff)
      4'h2:
        lin_frac = (prog < 8'h80)
          ? 8'(16'(prog) * 16'(knee) >> 7)
          : 8'(knee + 8'(16'(prog - 8'h80) * 16'(8'hFF - knee) >> 7));
      4'h3:
        if (prog < 8'h40)
          lin_frac = 8'(16'(prog) * 16'(knee_lo) >> 6);
        else if (prog < 8'hC0)
          lin_frac = 8'(knee_lo + 8'(16'(prog - 8'h40) * 16'(knee - knee_lo) >> 7));
        else
          lin_frac = 8'(knee + 8'(16'(prog - 8'hC0) * 16'(8'hFF - knee) >> 6));
      default: lin_frac = prog;
    endcase
  end

  ces_shape_lut u_lut (
    .tbl_i(prm_ff[1:0]),
    .prog_i(prog),
    .adapt_i(sty_ff == ces_pkg::STY_LUT_ADAPT_CORR || sty_ff == ces_pkg::STY_LUT_ADAPT),
    .corr_i(sty_ff == ces_pkg::STY_LUT_ADAPT_CORR),
    .supply_i(AMP_SUPPLY_I),
    .frac_o(lut_frac)
  );

  assign frac = (sty_ff >= ces_pkg::STY_LUT_FIXED) ? lut_frac : lin_frac;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_sty = sty_ff;
    nxt_prm = prm_ff;
    nxt_dbl = dbl_ff;
    nxt_num = num_ff;
    nxt_lvl = lvl_ff;
    nxt_idx = idx_ff;
    nxt_sub = sub_ff;
    nxt_amp = amp_ff;
    unique case (state_ff)
      ST_HIGH, ST_LOW:
        if (MOD_I == (state_ff == ST_HIGH))
        begin
          // Sampled only here, between edges
          nxt_sty = (state_ff == ST_HIGH) ? fall_sty : rise_sty;
          nxt_prm = (state_ff == ST_HIGH) ? fall_prm : rise_prm;
          nxt_dbl = count_ff[ces_pkg::DOUBLE_BIT];
          nxt_num = cfg_num;
          nxt_lvl = level_ff;
          nxt_idx = 5'h00;
          nxt_sub = 1'b0;
          if (!is_valid_style(nxt_sty, nxt_prm) || cfg_num == 5'h00)
          begin
            nxt_amp = (state_ff == ST_HIGH) ? level_ff : ces_pkg::FULL_CARRIER;
            nxt_state = (state_ff == ST_HIGH) ? ST_LOW : ST_HIGH;
          end
          else
            nxt_state = (state_ff == ST_HIGH) ? ST_FALL : ST_RISE;
        end
      ST_FALL, ST_RISE:
        if (tick)
        begin
          if (dbl_ff && !sub_ff)
            nxt_sub = 1'b1;
          else
          begin
            nxt_sub = 1'b0;
            nxt_idx = step;
            nxt_amp = (state_ff == ST_FALL) ? mix(ces_pkg::FULL_CARRIER, lvl_ff, frac)
                                            : mix(lvl_ff, ces_pkg::FULL_CARRIER, frac);
            if (step == num_ff)
            begin
              nxt_amp = (state_ff == ST_FALL) ? lvl_ff : ces_pkg::FULL_CARRIER;
              nxt_state = (state_ff == ST_FALL) ? ST_LOW : ST_HIGH;
            end
          end
        end
    endcase
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state_ff <= ST_HIGH;
      sty_ff <= 4'h0;
      prm_ff <= 3'h0;
      dbl_ff <= 1'b0;
      num_ff <= 5'h00;
      lvl_ff <= ces_pkg::RST_CARRIER_LEVEL;
      idx_ff <= 5'h00;
      sub_ff <= 1'b0;
      amp_ff <= ces_pkg::FULL_CARRIER;
    end
    else
    begin
      state_ff <= nxt_state;
      sty_ff <= nxt_sty;
      prm_ff <= nxt_prm;
      dbl_ff <= nxt_dbl;
      num_ff <= nxt_num;
      lvl_ff <= nxt_lvl;
      idx_ff <= nxt_idx;
      sub_ff <= nxt_sub;
      amp_ff <= nxt_amp;
    end
  end

  assign edge_run = (state_ff == ST_FALL) || (state_ff == ST_RISE);
  assign AMPL_O = amp_ff;
  assign EDGE_BUSY_O = edge_run;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);

  a_cfg_frozen_edge: assert property (edge_run ##1 edge_run |->
    $stable(sty_ff) && $stable(prm_ff) && $stable(num_ff) && $stable(lvl_ff))
    else $error("edge configuration changed during an edge");

  a_abrupt_reserved: assert property (state_ff == ST_HIGH && MOD_I
    && !is_valid_style(fall_sty, fall_prm) |=> state_ff == ST_LOW && amp_ff == $past(level_ff))
    else $error("reserved style did not give an abrupt step");

  a_single_step_len: assert property (edge_run && tick && !dbl_ff
    |=> idx_ff == 5'($past(idx_ff) + 5'h01))
    else $error("single-length state did not advance on its carrier cycle");

  a_double_step_hold: assert property (edge_run && tick && dbl_ff && !sub_ff
    |=> $stable(idx_ff) && sub_ff && $stable(amp_ff))
    else $error("double-length state advanced too early");

  a_step_count_bound: assert property (edge_run |-> idx_ff < num_ff)
    else $error("edge ran past its state count");

  a_fall_ends_level: assert property (state_ff == ST_FALL ##1 state_ff == ST_LOW
    |-> amp_ff == lvl_ff && idx_ff == num_ff)
    else $error("falling edge did not end at the modulated level");

  a_rise_ends_full: assert property (state_ff == ST_RISE ##1 state_ff == ST_HIGH
    |-> amp_ff == ces_pkg::FULL_CARRIER)
    else $error("rising edge did not end at full carrier");

  a_fall_kind_field: assert property (state_ff == ST_HIGH && MOD_I
    |=> sty_ff == $past(kind_ff[7:4]) && prm_ff == $past(param_ff[6:4]))
    else $error("falling edge latched the wrong fields");

  a_rise_kind_field: assert property (state_ff == ST_LOW && !MOD_I
    |=> sty_ff == $past(kind_ff[3:0]) && prm_ff == $past(param_ff[2:0]))
    else $error("rising edge latched the wrong fields");

  c_fall_shaped: cover property (state_ff == ST_FALL ##1 state_ff == ST_LOW);
  c_rise_double: cover property (state_ff == ST_RISE && dbl_ff ##1 state_ff == ST_HIGH);
  c_lut_adapt: cover property (edge_run && sty_ff == ces_pkg::STY_LUT_ADAPT_CORR);
  c_abrupt_step: cover property (state_ff == ST_HIGH ##1 state_ff == ST_LOW);

endmodule : ces_edge_shaper

// ---- hw/ces_pkg.sv ----
// Constants shared by the carrier edge shaper design files
package ces_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [15:0] ADDR_SHAPE_KIND = 16'h0041;
  localparam logic [15:0] ADDR_SHAPE_PARAM = 16'h0042;
  localparam logic [15:0] ADDR_STEP_COUNT = 16'h0043;
  localparam logic [15:0] ADDR_CARRIER_LEVEL = 16'h0044;
  localparam logic [15:0] ADDR_EDGE_STATUS = 16'h0048;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_SHAPE_KIND = 8'h11;
  localparam logic [7:0] RST_SHAPE_PARAM = 8'h00;
  localparam logic [7:0] RST_STEP_COUNT = 8'h04;
  localparam logic [7:0] RST_CARRIER_LEVEL = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int FALL_KIND_LSB = 4;
  localparam int RISE_KIND_LSB = 0;
  localparam int FALL_PARAM_LSB = 4;
  localparam int RISE_PARAM_LSB = 0;
  localparam int DOUBLE_BIT = 7;
  localparam int COUNT_LSB = 0;

  // ----------------------------------------
  // Edge style codes
  // ----------------------------------------
  typedef enum logic [3:0] {
    STY_LIN1 = 4'h1,
    STY_LIN2 = 4'h2,
    STY_LIN3 = 4'h3,
    STY_LUT_FIXED = 4'h4,
    STY_LUT_ADAPT_CORR = 4'h5,
    STY_LUT_ADAPT = 4'h6
  } ces_style_type;

  localparam logic [2:0] LUT_INDEX_MAX = 3'h3;
  localparam logic [7:0] FULL_CARRIER = 8'hFF;
  localparam logic [7:0] SUPPLY_NOMINAL = 8'h80;

  // ----------------------------------------
  // Timing: carrier cycle in system clock cycles
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int CARRIER_PERIOD_PS = 73746;
  localparam int CARRIER_RAW = CARRIER_PERIOD_PS / CLK_PERIOD_PS;
  localparam int CARRIER_CYCLES = (CARRIER_RAW < 1) ? 1 : CARRIER_RAW;

endpackage : ces_pkg

// ---- hw/ces_shape_lut.sv ----
// Table-driven edge profile with optional supply adaptation and correction
`timescale 1ns/1ps
module ces_shape_lut (
  input wire logic [1:0] tbl_i,
  input wire logic [7:0] prog_i,
  input wire logic adapt_i,
  input wire logic corr_i,
  input wire logic [7:0] supply_i,
  output logic [7:0] frac_o
);

  // ----------------------------------------
  // Profile tables, eight knots each, 255 implied at the end
  // ----------------------------------------
  localparam logic [7:0] KNOT [0:31] = '{
    8'h00, 8'h20, 8'h40, 8'h60, 8'h80, 8'hA0, 8'hC0, 8'hE0,
    8'h00, 8'h08, 8'h18, 8'h38, 8'h68, 8'hA0, 8'hD0, 8'hF0,
    8'h00, 8'h40, 8'h70, 8'h98, 8'hB8, 8'hD0, 8'hE4, 8'hF4,
    8'h00, 8'h10, 8'h30, 8'h60, 8'hA0, 8'hD0, 8'hEC, 8'hFA
  };

  logic [7:0] lo_k;
  logic [7:0] hi_k;
  logic [15:0] span;
  logic [8:0] base;
  logic signed [9:0] delta;
  logic signed [19:0] skew;
  logic signed [11:0] adapted;
  logic [15:0] bow;
  logic [9:0] fixed;

  always_comb
  begin
    lo_k = KNOT[{tbl_i, prog_i[7:5]}];
    hi_k = (prog_i[7:5] == 3'h7) ? 8'hFF : KNOT[{tbl_i, prog_i[7:5] + 3'h1}];
    span = 16'(hi_k - lo_k) * 16'(prog_i[4:0]);
    base = 9'(lo_k) + 9'(span[12:5]);
    // Supply above nominal flattens the profile, below steepens it
    delta = 10'(signed'({2'b00, supply_i})) - 10'(signed'({2'b00, ces_pkg::SUPPLY_NOMINAL}));
    skew = 20'(signed'({11'h000, base})) * 20'(delta);
    adapted = adapt_i ? 12'(signed'({3'b000, base})) - 12'(skew >>> 8)
                      : 12'(signed'({3'b000, base}));
    bow = 16'(base[7:0]) * 16'(8'hFF - base[7:0]);
    fixed = (adapted < 0) ? 10'h000 : adapted[9:0];
    if (corr_i)
      fixed = 10'(fixed + 10'(bow[15:10]));
    frac_o = (fixed > 10'h0FF) ? 8'hFF : fixed[7:0];
  end

endmodule : ces_shape_lut

// ---- hw/ces_tick_div.sv ----
// Divider that marks each carrier cycle with a one-cycle enable pulse
`timescale 1ns/1ps
module ces_tick_div #(
  parameter int DIV = ces_pkg::CARRIER_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic tick_o
);

  initial
  begin
    if (DIV < 1 || DIV > 255)
      $error("ces_tick_div: DIV out of range");
  end

  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic nxt_tick;
  logic tick_ff;

  always_comb
  begin
    nxt_tick = (cnt_ff == 8'(DIV - 1));
    nxt_cnt = nxt_tick ? 8'h00 : cnt_ff + 8'h01;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_ff <= 8'h00;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_o = tick_ff;

endmodule : ces_tick_div

// ---- test/ces_tx_model.sv ----
// Behavioural model of the transmitter amplitude stage and its supply sense
`timescale 1ns/1ps
module ces_tx_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] ampl_i,
  input wire logic clr_i,
  input wire logic [7:0] supply_set_i,
  output logic [7:0] supply_o,
  output logic [7:0] steps_o,
  output logic up_o
);
  // ----------------------------------------
  // Amplitude step tracking
  // ----------------------------------------
  logic [7:0] prev_ff;
  logic [7:0] nxt_steps;
  logic nxt_up;

  always_comb
  begin
    nxt_steps = steps_o;
    nxt_up = up_o;
    if (clr_i)
    begin
      nxt_steps = 8'h00;
      nxt_up = 1'b0;
    end
    else if (ampl_i != prev_ff)
    begin
      nxt_steps = steps_o + 8'h01;
      nxt_up = up_o | (ampl_i > prev_ff);
    end
  end

  // Supply sense lags one cycle, as a real measurement would
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prev_ff <= 8'hFF;
      steps_o <= 8'h00;
      up_o <= 1'b0;
      supply_o <= 8'h80;
    end
    else
    begin
      prev_ff <= ampl_i;
      steps_o <= nxt_steps;
      up_o <= nxt_up;
      supply_o <= supply_set_i;
    end
  end
endmodule : ces_tx_model

// ---- test/testbench.sv ----
// Self-checking testbench for the carrier edge shaper
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic CLK_SYS_I = 1'b0;
  logic RST_I = 1'b1;
  logic [15:0] ADDR_I = 16'h0000;
  logic [7:0] WDATA_I = 8'h00;
  logic WR_I = 1'b0;
  logic RD_I = 1'b0;
  logic MOD_I = 1'b0;
  logic [7:0] supply_set = ces_pkg::SUPPLY_NOMINAL;
  logic clr = 1'b0;
  logic [7:0] RDATA_O;
  logic [7:0] AMP_SUPPLY_I;
  logic [7:0] AMPL_O;
  logic [7:0] steps;
  logic EDGE_BUSY_O;
  logic up;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;

  always #12.5 CLK_SYS_I = ~CLK_SYS_I;

  // One carrier cycle per clock keeps the edges short
  ces_edge_shaper #(.CARRIER_DIV(1)) u_dut (
    .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .MOD_I(MOD_I),
    .AMP_SUPPLY_I(AMP_SUPPLY_I), .AMPL_O(AMPL_O), .EDGE_BUSY_O(EDGE_BUSY_O));

  ces_tx_model u_tx (
    .clk_i(CLK_SYS_I), .rst_i(RST_I), .ampl_i(AMPL_O), .clr_i(clr),
    .supply_set_i(supply_set), .supply_o(AMP_SUPPLY_I), .steps_o(steps), .up_o(up));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1)
    begin
      $display("FAIL %0t %s", $time, msg);
      fail_count++;
    end
  endtask : check

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge CLK_SYS_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge CLK_SYS_I);
    WR_I <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge CLK_SYS_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge CLK_SYS_I);
    RD_I <= 1'b0;
    @(negedge CLK_SYS_I);
    check(RDATA_O === e, $sformatf("read %h got %h", a, RDATA_O));
  endtask : rd

  // Busy cycles are counted from the first cycle after the request is taken
  task automatic run_edge(input logic m, input logic [7:0] amp, input int lo, input int hi);
    int n;
    n = 0;
    @(posedge CLK_SYS_I);
    clr <= 1'b1;
    @(posedge CLK_SYS_I);
    clr <= 1'b0;
    MOD_I <= m;
    @(negedge CLK_SYS_I);
    @(negedge CLK_SYS_I);
    while (EDGE_BUSY_O === 1'b1 && n < 300)
    begin
      n++;
      @(negedge CLK_SYS_I);
    end
    check(AMPL_O === amp && n >= lo && n <= hi, $sformatf("edge amp %h busy %0d", AMPL_O, n));
  endtask : run_edge

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(ces_pkg::ADDR_SHAPE_KIND, ces_pkg::RST_SHAPE_KIND);
    rd(ces_pkg::ADDR_SHAPE_PARAM, ces_pkg::RST_SHAPE_PARAM);
    rd(ces_pkg::ADDR_STEP_COUNT, ces_pkg::RST_STEP_COUNT);
    rd(ces_pkg::ADDR_CARRIER_LEVEL, ces_pkg::RST_CARRIER_LEVEL);
    wr(ces_pkg::ADDR_SHAPE_PARAM, 8'hFF);
    rd(ces_pkg::ADDR_SHAPE_PARAM, 8'hFF);
    wr(ces_pkg::ADDR_EDGE_STATUS, 8'hFF);
    rd(ces_pkg::ADDR_EDGE_STATUS, 8'h00);
    wr(16'h0045, 8'hAA);
    rd(16'h0045, ces_pkg::READ_UNMAPPED);
    $display("test regs done");
  endtask : t_regs

  // Zero states and reserved codes both give a single step
  task automatic t_abrupt;
    logic [7:0] lv [3] = '{8'h00, 8'h5A, 8'hFF};
    logic [3:0] rc [3] = '{4'h0, 4'h7, 4'hF};
    wr(ces_pkg::ADDR_SHAPE_KIND, 8'h11);
    wr(ces_pkg::ADDR_STEP_COUNT, 8'h00);
    foreach (lv[i])
    begin
      wr(ces_pkg::ADDR_CARRIER_LEVEL, lv[i]);
      run_edge(1'b1, lv[i], 0, 0);
      // The model counts a change one clock after it shows
      @(negedge CLK_SYS_I);
      check(steps === ((lv[i] == 8'hFF) ? 8'h00 : 8'h01), "abrupt fall steps");
      run_edge(1'b0, ces_pkg::FULL_CARRIER, 0, 0);
    end
    wr(ces_pkg::ADDR_STEP_COUNT, 8'h04);
    wr(ces_pkg::ADDR_CARRIER_LEVEL, 8'h5A);
    foreach (rc[i])
    begin
      wr(ces_pkg::ADDR_SHAPE_KIND, {rc[i], rc[i]});
      run_edge(1'b1, 8'h5A, 0, 0);
      run_edge(1'b0, ces_pkg::FULL_CARRIER, 0, 0);
    end
    $display("test abrupt done");
  endtask : t_abrupt

  task automatic t_linear;
    int cnt [3] = '{1, 4, 31};
    wr(ces_pkg::ADDR_CARRIER_LEVEL, 8'h20);
    for (int s = 1; s <= 3; s++)
    begin
      wr(ces_pkg::ADDR_SHAPE_KIND, {s[3:0], s[3:0]});
      wr(ces_pkg::ADDR_SHAPE_PARAM, {1'b0, s[2:0] + 3'h4, 1'b0, s[2:0]});
      foreach (cnt[i])
      begin
        wr(ces_pkg::ADDR_STEP_COUNT, {3'h0, cnt[i][4:0]});
        run_edge(1'b1, 8'h20, cnt[i], cnt[i] + 2);
        check(up === 1'b0 && (cnt[i] < 4 || steps >= 8'h02), "linear fall");
        run_edge(1'b0, ces_pkg::FULL_CARRIER, cnt[i], cnt[i] + 2);
      end
    end
    $display("test linear done");
  endtask : t_linear

  task automatic t_double;
    logic [7:0] cv [3] = '{8'h84, 8'hE4, 8'h64};
    int lo [3] = '{8, 8, 4};
    wr(ces_pkg::ADDR_SHAPE_KIND, 8'h22);
    foreach (cv[i])
    begin
      wr(ces_pkg::ADDR_STEP_COUNT, cv[i]);
      run_edge(1'b1, 8'h20, lo[i], lo[i] + 2);
      run_edge(1'b0, ces_pkg::FULL_CARRIER, lo[i], lo[i] + 2);
    end
    $display("test double done");
  endtask : t_double

  // Reserved bits 7 and 3 of the param byte are set throughout
  task automatic t_lut;
    wr(ces_pkg::ADDR_STEP_COUNT, 8'h04);
    for (int s = 4; s <= 6; s++)
    begin
      supply_set <= (s == 4) ? ces_pkg::SUPPLY_NOMINAL : 8'h60;
      wr(ces_pkg::ADDR_SHAPE_KIND, {s[3:0], s[3:0]});
      for (int x = 0; x <= 4; x++)
      begin
        wr(ces_pkg::ADDR_SHAPE_PARAM, {1'b1, x[2:0], 1'b1, x[2:0]});
        run_edge(1'b1, 8'h20, (x < 4) ? 4 : 0, (x < 4) ? 6 : 0);
        check(up === 1'b0, "table fall went up");
        run_edge(1'b0, ces_pkg::FULL_CARRIER, (x < 4) ? 4 : 0, (x < 4) ? 6 : 0);
      end
    end
    $display("test lut done");
  endtask : t_lut

  // Writes made during a shaped edge must only affect the next one
  task automatic t_mid;
    int n;
    n = 0;
    wr(ces_pkg::ADDR_SHAPE_KIND, 8'h11);
    wr(ces_pkg::ADDR_STEP_COUNT, 8'h08);
    @(posedge CLK_SYS_I);
    MOD_I <= 1'b1;
    wr(ces_pkg::ADDR_STEP_COUNT, 8'h00);
    @(negedge CLK_SYS_I);
    while (EDGE_BUSY_O === 1'b1 && n < 300)
    begin
      n++;
      @(negedge CLK_SYS_I);
    end
    check(n >= 6 && n <= 10 && AMPL_O === 8'h20, "edge altered midway");
    run_edge(1'b0, ces_pkg::FULL_CARRIER, 0, 0);
    $display("test midedge done");
  endtask : t_mid

  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  always @(posedge CLK_SYS_I)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      stop_test();
    end
  end

  initial
  begin
    repeat (16) @(posedge CLK_SYS_I);
    RST_I <= 1'b0;
    @(negedge CLK_SYS_I);
    check(AMPL_O === ces_pkg::FULL_CARRIER && EDGE_BUSY_O === 1'b0, "reset outputs");
    t_regs();
    t_abrupt();
    t_linear();
    t_double();
    t_lut();
    t_mid();
    stop_test();
  end
endmodule : testbench
